/* include/vlsw_pkg.sv */
// shared constants, types and register map of the video link switch control
package vlsw_pkg;

    // routing modes; the fourth two-bit code is never stored
    typedef enum logic [1:0] {VLSW_QUAD, VLSW_DUAL, VLSW_SINGLE} vlsw_mode_t;

    // structure sizes
    localparam int VLSW_OUTS = 4;          // output channels of the link
    localparam int VLSW_INPUTS = 16;       // high speed input channels
    localparam int VLSW_EQ_CH = 8;         // channels with an equalizer bit
    localparam int VLSW_IDX_W = 4;         // width of one source index
    localparam int VLSW_ROUTE_W = VLSW_OUTS * VLSW_IDX_W;

    // register bus address layout
    localparam int VLSW_ADDR_W = 11;       // byte address width
    localparam int VLSW_OFF_MSB = 7;       // offset field [7:0]
    localparam int VLSW_DEV_LSB = 8;       // slave select field [10:8]
    localparam int VLSW_DEV_MSB = 10;

    // register byte offsets
    localparam logic [7:0] VLSW_OFF_HS_MODE = 8'h00;
    localparam logic [7:0] VLSW_OFF_AUX_MODE = 8'h04;
    localparam logic [7:0] VLSW_OFF_TERM_PULSE = 8'h08;
    localparam logic [7:0] VLSW_OFF_RX_SET = 8'h0C;
    localparam logic [7:0] VLSW_OFF_INPUT_EQUALIZER_LEVEL = 8'h10;
    localparam logic [7:0] VLSW_OFF_STATUS = 8'h14;

    // field positions
    localparam int VLSW_MODE_LSB = 0;      // mode field [1:0]
    localparam int VLSW_MODE_MSB = 1;
    localparam int VLSW_CHAN_LSB = 4;      // channel field [7:4]
    localparam int VLSW_CHAN_MSB = 7;
    localparam int VLSW_GOFF_BIT = 0;      // global termination off
    localparam int VLSW_STAT_LOCK_BIT = 16;
    localparam int VLSW_STAT_PULSE_BIT = 17;
    localparam logic [1:0] VLSW_MODE_BAD = 2'h3;

    // axi responses
    localparam logic [1:0] VLSW_RESP_OKAY = 2'h0;
    localparam logic [1:0] VLSW_RESP_SLVERR = 2'h2;
    localparam logic [1:0] VLSW_RESP_DECERR = 2'h3;

    // termination pulse timing
    localparam int VLSW_CLK_PERIOD_NS = 10;
    localparam int VLSW_NS_PER_MS = 1000000;
    localparam int VLSW_PULSE_TIME_MS = 100;
    localparam int VLSW_PULSE_CYCLES =
        VLSW_PULSE_TIME_MS * VLSW_NS_PER_MS / VLSW_CLK_PERIOD_NS;
    localparam int VLSW_PULSE_CNT_W = 24;

    // software controlled settings
    typedef struct packed {
        vlsw_mode_t hs_mode;
        logic [VLSW_IDX_W-1:0] hs_chan;
        vlsw_mode_t aux_mode;
        logic [VLSW_IDX_W-1:0] aux_chan;
        logic [VLSW_INPUTS-1:0] term_pulse_en;
        logic term_global_off;
        logic [VLSW_EQ_CH-1:0] eq_level;
    } vlsw_ctrl_t;

    localparam vlsw_ctrl_t VLSW_CTRL_RESET = '{
        hs_mode: VLSW_QUAD,
        hs_chan: 4'h0,
        aux_mode: VLSW_QUAD,
        aux_chan: 4'h0,
        term_pulse_en: 16'h0000,
        term_global_off: 1'b0,
        eq_level: 8'h00
    };

    // board pins, carried through the synchroniser together
    typedef struct packed {
        logic reset_n;
        logic [2:0] slave_addr;
        logic [1:0] channel_select;
        logic equalizer_level;
    } vlsw_pins_t;

    localparam vlsw_pins_t VLSW_PINS_IDLE = '{
        reset_n: 1'b1,
        slave_addr: 3'h0,
        channel_select: 2'h0,
        equalizer_level: 1'b0
    };

    // quad mode, link 0: output k takes input k
    localparam logic [VLSW_ROUTE_W-1:0] VLSW_ROUTE_RESET = 16'h3210;

endpackage

/* rtl/vlsw_ctrl.sv */
// control logic of the four input video link switch
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns

module vlsw_ctrl
    import vlsw_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = VLSW_PULSE_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [VLSW_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [VLSW_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pin_reset_n,
    input wire logic [2:0] pin_slave_addr,
    input wire logic [1:0] pin_channel_select,
    input wire logic pin_equalizer_level,
    output logic [VLSW_ROUTE_W-1:0] hs_route,
    output logic [VLSW_ROUTE_W-1:0] aux_route,
    output logic [VLSW_INPUTS-1:0] input_term_disconnect,
    output logic [VLSW_EQ_CH-1:0] input_equalizer_level,
    output logic serial_active
);

    // read one register; top bit flags a mapped offset
    function automatic logic [32:0] reg_read(
        input logic [7:0] off,
        input vlsw_ctrl_t c,
        input logic [31:0] stat
    );
        logic [32:0] r;
        r = 33'h0;
        case (off)
            VLSW_OFF_HS_MODE: r = {1'b1, 24'h0, c.hs_chan, 2'h0, c.hs_mode};
            VLSW_OFF_AUX_MODE:
                r = {1'b1, 24'h0, c.aux_chan, 2'h0, c.aux_mode};
            VLSW_OFF_TERM_PULSE: r = {1'b1, 16'h0, c.term_pulse_en};
            VLSW_OFF_RX_SET: r = {1'b1, 31'h0, c.term_global_off};
            VLSW_OFF_INPUT_EQUALIZER_LEVEL: r = {1'b1, 24'h0, c.eq_level};
            VLSW_OFF_STATUS: r = {1'b1, stat};
            default: r = 33'h0;
        endcase
        return r;
    endfunction

    // pin synchroniser: stage one feeds stage two only
    vlsw_pins_t pins_meta;
    vlsw_pins_t pins_q;
    wire vlsw_pins_t pins_raw = '{
        reset_n: pin_reset_n,
        slave_addr: pin_slave_addr,
        channel_select: pin_channel_select,
        equalizer_level: pin_equalizer_level
    };

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pins_meta <= VLSW_PINS_IDLE;
            pins_q <= VLSW_PINS_IDLE;
        end
        else
        begin
            pins_meta <= pins_raw;
            pins_q <= pins_meta;
        end
    end

    // control registers drop on either reset source
    wire ctrl_rst = !aresetn || !pins_q.reset_n;

    // settings, lock and pulse state
    vlsw_ctrl_t ctrl;
    vlsw_ctrl_t next_ctrl;
    logic serial_locked;
    logic [VLSW_PULSE_CNT_W-1:0] pulse_cnt;

    // write path holding registers
    logic aw_held;
    logic w_held;
    logic [VLSW_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // handshakes; one write and one read at a time
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    // write decode; a foreign slave select is left alone
    wire wr_commit = aw_held && w_held && !s_axi_bvalid;
    wire wr_dev_hit =
        wr_addr[VLSW_DEV_MSB:VLSW_DEV_LSB] == pins_q.slave_addr;
    wire [7:0] wr_off = wr_addr[VLSW_OFF_MSB:0];
    wire [31:0] status_word;
    wire [32:0] wr_old = reg_read(wr_off, ctrl, status_word);
    wire wr_mapped = wr_old[32];
    wire wr_do = wr_commit && wr_dev_hit;
    wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                           {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [31:0] wr_val = (wr_old[31:0] & ~wr_mask) | (wr_data & wr_mask);
    wire [1:0] wr_resp = !wr_dev_hit ? VLSW_RESP_DECERR :
                         !wr_mapped ? VLSW_RESP_SLVERR : VLSW_RESP_OKAY;

    // read decode
    wire rd_dev_hit =
        s_axi_araddr[VLSW_DEV_MSB:VLSW_DEV_LSB] == pins_q.slave_addr;
    wire [32:0] rd_word =
        reg_read(s_axi_araddr[VLSW_OFF_MSB:0], ctrl, status_word);
    wire rd_do = ar_take && rd_dev_hit;
    wire [1:0] rd_resp = !rd_dev_hit ? VLSW_RESP_DECERR :
                         !rd_word[32] ? VLSW_RESP_SLVERR : VLSW_RESP_OKAY;

    // mode fields; the unused code leaves the mode as it was
    wire [1:0] wr_mode = wr_val[VLSW_MODE_MSB:VLSW_MODE_LSB];
    wire wr_mode_ok = wr_mode != VLSW_MODE_BAD;
    wire [VLSW_IDX_W-1:0] wr_chan = wr_val[VLSW_CHAN_MSB:VLSW_CHAN_LSB];

    // register update from a committed write
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_do)
        begin
            case (wr_off)
                VLSW_OFF_HS_MODE:
                begin
                    next_ctrl.hs_chan = wr_chan;
                    if (wr_mode_ok)
                        next_ctrl.hs_mode = vlsw_mode_t'(wr_mode);
                end
                VLSW_OFF_AUX_MODE:
                begin
                    next_ctrl.aux_chan = wr_chan;
                    if (wr_mode_ok)
                        next_ctrl.aux_mode = vlsw_mode_t'(wr_mode);
                end
                VLSW_OFF_TERM_PULSE:
                    next_ctrl.term_pulse_en = wr_val[VLSW_INPUTS-1:0];
                VLSW_OFF_RX_SET:
                    next_ctrl.term_global_off = wr_val[VLSW_GOFF_BIT];
                VLSW_OFF_INPUT_EQUALIZER_LEVEL:
                    next_ctrl.eq_level = wr_val[VLSW_EQ_CH-1:0];
                default: next_ctrl = ctrl;  // status is read only
            endcase
        end
    end

    // settings and lock; only a reset reopens the pins
    always_ff @(posedge aclk)
    begin
        if (ctrl_rst)
        begin
            ctrl <= VLSW_CTRL_RESET;
            serial_locked <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            serial_locked <= serial_locked || wr_do || rd_do;
        end
    end

    // write channel capture, either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
        end
        else
        begin
            if (aw_take)
                wr_addr <= s_axi_awaddr;
            if (w_take)
            begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            aw_held <= wr_commit ? 1'b0 : (aw_held || aw_take);
            w_held <= wr_commit ? 1'b0 : (w_held || w_take);
        end
    end

    // write response, held until bready
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= VLSW_RESP_OKAY;
        end
        else if (wr_commit)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read data, one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= VLSW_RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_dev_hit ? rd_word[31:0] : 32'h0;
            s_axi_rresp <= rd_resp;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // effective selection: pins force quad and share one select
    wire vlsw_mode_t eff_hs_mode =
        serial_locked ? ctrl.hs_mode : VLSW_QUAD;
    wire vlsw_mode_t eff_aux_mode =
        serial_locked ? ctrl.aux_mode : VLSW_QUAD;
    wire [VLSW_IDX_W-1:0] pin_chan = {2'h0, pins_q.channel_select};
    wire [VLSW_IDX_W-1:0] eff_hs_chan =
        serial_locked ? ctrl.hs_chan : pin_chan;
    wire [VLSW_IDX_W-1:0] eff_aux_chan =
        serial_locked ? ctrl.aux_chan : pin_chan;
    wire [VLSW_ROUTE_W-1:0] next_hs_route;
    wire [VLSW_ROUTE_W-1:0] next_aux_route;

    // data channel selector, lanes of a link kept together in quad mode
    vlsw_route u_hs_route (
        .mode(eff_hs_mode),
        .chan(eff_hs_chan),
        .route(next_hs_route)
    );

    // auxiliary selector, own mode under serial control
    vlsw_route u_aux_route (
        .mode(eff_aux_mode),
        .chan(eff_aux_chan),
        .route(next_aux_route)
    );

    // a source switch is any move of the data route
    wire route_change = next_hs_route != hs_route;
    wire pulse_on = pulse_cnt != '0;
    wire [VLSW_PULSE_CNT_W-1:0] pulse_load = VLSW_PULSE_CNT_W'(PULSE_CYCLES);

    // pulse timer; a new switch restarts the full interval
    always_ff @(posedge aclk)
    begin
        if (ctrl_rst)
            pulse_cnt <= '0;
        else if (route_change)
            pulse_cnt <= pulse_load;
        else if (pulse_on)
            pulse_cnt <= pulse_cnt - 1'b1;
    end

    // termination: pins keep every input terminated
    wire [VLSW_INPUTS-1:0] pulse_mask = ctrl.term_pulse_en & {
        VLSW_INPUTS{pulse_on}};
    wire [VLSW_INPUTS-1:0] serial_term =
        {VLSW_INPUTS{ctrl.term_global_off}} | pulse_mask;
    wire [VLSW_INPUTS-1:0] next_term =
        serial_locked ? serial_term : '0;
    wire [VLSW_EQ_CH-1:0] next_eq = serial_locked ? ctrl.eq_level :
        {VLSW_EQ_CH{pins_q.equalizer_level}};

    assign status_word = {14'h0, pulse_on, serial_locked,
                          input_term_disconnect};

    // registered outputs toward the analogue side
    always_ff @(posedge aclk)
    begin
        if (ctrl_rst)
        begin
            hs_route <= VLSW_ROUTE_RESET;
            aux_route <= VLSW_ROUTE_RESET;
            input_term_disconnect <= '0;
            input_equalizer_level <= '0;
            serial_active <= 1'b0;
        end
        else
        begin
            hs_route <= next_hs_route;
            aux_route <= next_aux_route;
            input_term_disconnect <= next_term;
            input_equalizer_level <= next_eq;
            serial_active <= serial_locked;
        end
    end

    // lock holds once any addressed access is seen
    AST_LOCK_STICKY: assert property (@(posedge aclk) disable iff (ctrl_rst)
        (serial_locked || wr_do || rd_do) |=> serial_locked)
        else $error("serial lock dropped without reset");

    AST_RESET_DEFAULTS: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ctrl_rst |=> (ctrl == VLSW_CTRL_RESET) && !serial_locked)
        else $error("control registers not at defaults after reset");

    // a foreign read must not set the lock; only a write in the same cycle may
    AST_FOREIGN_ADDR: assert property (@(posedge aclk)
        disable iff (ctrl_rst)
        (ar_take && !rd_dev_hit) |=> s_axi_rvalid &&
            (s_axi_rresp == VLSW_RESP_DECERR) &&
            (serial_locked == $past(serial_locked || wr_do)))
        else $error("foreign slave select not refused");

    AST_SINGLE_MODE: assert property (@(posedge aclk)
        disable iff (ctrl_rst)
        (serial_locked && ctrl.hs_mode == VLSW_SINGLE) |=>
            hs_route == {VLSW_OUTS{$past(ctrl.hs_chan)}})
        else $error("single mode does not fan one input out");

    AST_RESET_QUAD: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ctrl_rst |=> (ctrl.hs_mode == VLSW_QUAD) &&
            (hs_route == VLSW_ROUTE_RESET))
        else $error("routing not quad after reset");

    AST_AUX_INDEPENDENT: assert property (@(posedge aclk)
        disable iff (ctrl_rst)
        (wr_do && wr_off == VLSW_OFF_HS_MODE) |=>
            $stable(ctrl.aux_mode) && $stable(ctrl.aux_chan))
        else $error("data mode write disturbed auxiliary mode");

    AST_PIN_SHARED: assert property (@(posedge aclk) disable iff (ctrl_rst)
        !serial_locked |=> hs_route == aux_route)
        else $error("pin control routes data and aux apart");

    AST_QUAD_LANES: assert property (@(posedge aclk)
        disable iff (ctrl_rst)
        (serial_locked && ctrl.hs_mode == VLSW_QUAD) |=>
            hs_route == {$past(ctrl.hs_chan[1:0]), 2'h3,
                         $past(ctrl.hs_chan[1:0]), 2'h2,
                         $past(ctrl.hs_chan[1:0]), 2'h1,
                         $past(ctrl.hs_chan[1:0]), 2'h0})
        else $error("lanes of one link routed differently");

    AST_PULSE_TERM: assert property (@(posedge aclk)
        disable iff (ctrl_rst)
        (pulse_on && serial_locked && !ctrl.term_global_off) |=>
            input_term_disconnect == $past(ctrl.term_pulse_en))
        else $error("pulse enabled inputs not disconnected");

    AST_GLOBAL_OFF: assert property (@(posedge aclk)
        disable iff (ctrl_rst)
        (serial_locked && ctrl.term_global_off) |=>
            input_term_disconnect == '1)
        else $error("global termination off not applied");

    AST_PIN_TERM_ON: assert property (@(posedge aclk)
        disable iff (ctrl_rst)
        !serial_locked |=> input_term_disconnect == '0)
        else $error("termination dropped under pin control");

    AST_SERIAL_EQ: assert property (@(posedge aclk) disable iff (ctrl_rst)
        serial_locked |=>
            input_equalizer_level == $past(ctrl.eq_level))
        else $error("equalizer not taken from register");

    // the edge that ends a reset still clears outputs, so skip it
    AST_PIN_EQ: assert property (@(posedge aclk) disable iff (ctrl_rst)
        (!ctrl_rst && !serial_locked) |=> input_equalizer_level ==
            {VLSW_EQ_CH{$past(pins_q.equalizer_level)}})
        else $error("pin equalizer level not applied to all");

    AST_SWITCH_PULSE: assert property (@(posedge aclk)
        disable iff (ctrl_rst)
        (!ctrl_rst && route_change) |=>
            (pulse_cnt == pulse_load) ##1 pulse_on)
        else $error("selection change did not restart pulse");

endmodule

/* rtl/vlsw_route.sv */
// source index per output channel for one routing mode and selection
`timescale 1ns/1ns
module vlsw_route
    import vlsw_pkg::*;
(
    input vlsw_mode_t mode,
    input wire logic [VLSW_IDX_W-1:0] chan,
    output logic [VLSW_ROUTE_W-1:0] route
);

    genvar k;

    // one selector per output channel
    generate
        for (k = 0; k < VLSW_OUTS; k++)
        begin : g_out
            localparam logic [1:0] OUT_K = 2'(k);
            // quad: whole link, channel k of it, so every lane matches
            wire [VLSW_IDX_W-1:0] quad_src = {chan[1:0], OUT_K};
            // dual: two locked 8:1 selectors over pairs of channels
            wire [VLSW_IDX_W-1:0] dual_src = {chan[2:0], OUT_K[0]};
            // single: one of 16 inputs fanned out to all outputs
            wire [VLSW_IDX_W-1:0] single_src = chan;
            assign route[k*VLSW_IDX_W +: VLSW_IDX_W] =
                (mode == VLSW_QUAD) ? quad_src :
                (mode == VLSW_DUAL) ? dual_src : single_src;
        end
    endgenerate

endmodule

/* verification/tb.sv */
// self-checking bench of the video link switch control
`timescale 1ns/1ns
module tb;
    import vlsw_pkg::*;
    localparam int PULSE = 20; // shortened so a pulse ends quickly
    localparam logic [2:0] DEV = 3'h5; // strap on this board
    localparam logic [2:0] BAD = 3'h2; // some other switch on the bus
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [VLSW_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF; // whole words only
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, serial_active;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [VLSW_ROUTE_W-1:0] hs_route, aux_route;
    logic [VLSW_INPUTS-1:0] input_term_disconnect;
    logic [VLSW_EQ_CH-1:0] input_equalizer_level;
    logic b_rst_n = 1'b1; // board reset switch
    logic [1:0] b_chan = 2'h0; // board link select
    logic b_eq = 1'b0; // board equalizer jumper
    vlsw_pins_t pins;
    int num_errors = 0, compares = 0, cycles = 0;

    vlsw_board #(.STRAP(DEV)) vlsw_board_inst (.aclk, .want_rst_n(b_rst_n),
        .want_chan(b_chan), .want_eq(b_eq), .pins);
    vlsw_ctrl #(.PULSE_CYCLES(PULSE)) vlsw_ctrl_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pin_reset_n(pins.reset_n), .pin_slave_addr(pins.slave_addr),
        .pin_channel_select(pins.channel_select),
        .pin_equalizer_level(pins.equalizer_level), .hs_route, .aux_route,
        .input_term_disconnect, .input_equalizer_level, .serial_active);

    // 100 MHz clock
    always #5 aclk = ~aclk;

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            num_errors++;
            summarize();
        end
    end

    task summarize;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // value compare
    task cmp_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bus response compare
    task cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // one write; address and data offered together, each dropped when taken
    task wr(input logic [7:0] off, input logic [31:0] d,
        input logic [2:0] dev, input logic [1:0] exp);
        s_axi_awaddr <= {dev, off};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        cmp_resp(s_axi_bresp, exp);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    // one read; data and response taken at the edge rvalid is seen
    task rd(input logic [7:0] off, input logic [31:0] expd,
        input logic [2:0] dev, input logic [1:0] exp);
        s_axi_araddr <= {dev, off};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        cmp_resp(s_axi_rresp, exp);
        cmp_val(s_axi_rdata, expd);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // defaults straight after reset
    task t_reset;
        idle(2);
        cmp_val(hs_route, 16'h3210);
        cmp_val(aux_route, 16'h3210);
        cmp_val(input_term_disconnect, 16'h0000);
        cmp_val(serial_active, 1'b0);
    endtask

    // pins steer both routes and all equalizers; terminations stay on
    task t_pins;
        b_chan <= 2'h2;
        b_eq <= 1'b1;
        idle(8);
        cmp_val(hs_route, 16'hBA98);
        cmp_val(aux_route, 16'hBA98);
        cmp_val(input_equalizer_level, 8'hFF);
        cmp_val(input_term_disconnect, 16'h0000);
        wr(VLSW_OFF_HS_MODE, 32'h52, BAD, VLSW_RESP_DECERR);
        rd(VLSW_OFF_HS_MODE, 32'h0, BAD, VLSW_RESP_DECERR);
        idle(3);
        cmp_val(serial_active, 1'b0);
        cmp_val(hs_route, 16'hBA98);
    endtask

    // first serial access takes over; a route change pulses enabled inputs
    task t_lock;
        wr(VLSW_OFF_TERM_PULSE, 32'h00F0, DEV, VLSW_RESP_OKAY);
        idle(PULSE + 10);
        cmp_val(serial_active, 1'b1);
        cmp_val(hs_route, 16'h3210);
        wr(VLSW_OFF_HS_MODE, 32'h10, DEV, VLSW_RESP_OKAY);
        idle(4);
        cmp_val(hs_route, 16'h7654);
        cmp_val(input_term_disconnect, 16'h00F0);
        idle(PULSE + 5);
        cmp_val(input_term_disconnect, 16'h0000);
        b_chan <= 2'h3;
        idle(8);
        cmp_val(hs_route, 16'h7654);
        cmp_val(input_equalizer_level, 8'h00);
    endtask

    // dual and single modes; aux mode kept apart from data mode
    task t_modes;
        wr(VLSW_OFF_HS_MODE, 32'h31, DEV, VLSW_RESP_OKAY);
        idle(4);
        cmp_val(hs_route, 16'h7676);
        wr(VLSW_OFF_HS_MODE, 32'h52, DEV, VLSW_RESP_OKAY);
        idle(4);
        cmp_val(hs_route, 16'h5555);
        cmp_val(aux_route, 16'h3210);
        // unused mode code keeps single mode, channel still moves
        wr(VLSW_OFF_HS_MODE, 32'h43, DEV, VLSW_RESP_OKAY);
        idle(4);
        cmp_val(hs_route, 16'h4444);
        wr(VLSW_OFF_AUX_MODE, 32'h92, DEV, VLSW_RESP_OKAY);
        idle(4);
        cmp_val(aux_route, 16'h9999);
        cmp_val(hs_route, 16'h4444);
    endtask

    // per channel equalizers, global termination off, unmapped read
    task t_rx;
        wr(VLSW_OFF_INPUT_EQUALIZER_LEVEL, 32'hA5, DEV, VLSW_RESP_OKAY);
        idle(4);
        cmp_val(input_equalizer_level, 8'hA5);
        rd(VLSW_OFF_INPUT_EQUALIZER_LEVEL, 32'hA5, DEV, VLSW_RESP_OKAY);
        wr(VLSW_OFF_RX_SET, 32'h1, DEV, VLSW_RESP_OKAY);
        idle(4);
        cmp_val(input_term_disconnect, 16'hFFFF);
        rd(8'h3C, 32'h0, DEV, VLSW_RESP_SLVERR);
        // status: all terminations off, locked, last pulse long over
        rd(VLSW_OFF_STATUS, 32'h0001FFFF, DEV, VLSW_RESP_OKAY);
    endtask

    // board reset pin clears settings, lock and outputs and hands control back to pins
    task t_pin_reset;
        b_rst_n <= 1'b0;
        b_eq <= 1'b1;
        idle(6);
        b_rst_n <= 1'b1;
        idle(10);
        cmp_val(serial_active, 1'b0);
        cmp_val(hs_route, 16'hFEDC);
        cmp_val(input_term_disconnect, 16'h0000);
        cmp_val(input_equalizer_level, 8'hFF);
    endtask

    // main sequence
    initial
    begin
        idle(20);
        aresetn <= 1'b1;
        t_reset();
        t_pins();
        t_lock();
        t_modes();
        t_rx();
        t_pin_reset();
        summarize();
    end
endmodule

/* verification/vlsw_board.sv */
// board pin model: straps and parallel control pins at the switch
`timescale 1ns/1ns
module vlsw_board
    import vlsw_pkg::*;
#(
    parameter logic [2:0] STRAP = 3'h5 // slave select jumpers
)
(
    input wire logic aclk,
    input wire logic want_rst_n,
    input wire logic [1:0] want_chan,
    input wire logic want_eq,
    output vlsw_pins_t pins = VLSW_PINS_IDLE
);
    // jumpers move only just after an edge, never in mid-cycle
    always @(posedge aclk)
    begin
        pins.reset_n <= want_rst_n;
        pins.slave_addr <= STRAP;
        pins.channel_select <= want_chan;
        pins.equalizer_level <= want_eq;
    end
endmodule
